// ==== ald_core.sv ====
// Execution datapath: working registers, flags, program counter and stack
`timescale 1ns/1ps
module ald_core #(
   parameter int STACK_DEPTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic op_valid,
   input wire ald_pkg::ald_op_t op_code,
   input wire logic [4:0] op_rd,
   input wire logic [4:0] op_rr,
   input wire logic [7:0] op_imm,
   input wire logic [2:0] op_bit,
   input wire logic [11:0] op_offset,
   input wire logic [15:0] op_target,
   input wire logic next_is_two_word,
   input wire logic io_bit_value,
   input wire logic [4:0] peek_index,
   output logic op_ready,
   output logic op_done,
   output logic [15:0] pc,
   output logic [7:0] status_flags,
   output logic [7:0] peek_data
);
   localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

   generate
      if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
         $error("STACK_DEPTH must be a power of two of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [31:0][7:0] gpr;
      logic [STACK_DEPTH-1:0][15:0] stk;
      logic [SP_W-1:0] sp;
      logic [15:0] pc;
      logic [7:0] flags;
      logic ready;
      logic done;
      logic [2:0] cnt;
      logic [7:0] peek;
   } ald_state_t;

   ald_state_t state_reg;
   ald_state_t state_next;

   logic accept;
   logic [7:0] rd_val;
   logic [7:0] rr_val;
   logic [7:0] alu_b;
   logic alu_cin;
   logic alu_sub;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_h;
   logic alu_v;
   logic alu_n;
   logic alu_z;
   logic [15:0] rel_target;
   logic [15:0] zptr;
   logic [4:0] pair_lo;
   logic [4:0] pair_hi;
   logic [15:0] word_val;
   logic [15:0] word_res;
   logic skip_cond;
   logic [7:0] logic_res;

   assign accept = op_valid && state_reg.ready;
   assign rd_val = state_reg.gpr[op_rd];
   assign rr_val = state_reg.gpr[op_rr];
   assign zptr = {state_reg.gpr[ald_pkg::ZPTR_HIGH], state_reg.gpr[ald_pkg::ZPTR_LOW]};
   assign rel_target = state_reg.pc + {{4{op_offset[11]}}, op_offset} + ald_pkg::PC_STEP;
   assign pair_lo = {op_rd[4:1], 1'b0};
   assign pair_hi = {op_rd[4:1], 1'b1};
   assign word_val = {state_reg.gpr[pair_hi], state_reg.gpr[pair_lo]};

   // Operand and mode selection for the byte adder
   always_comb begin
      alu_b = rr_val;
      alu_cin = 1'b0;
      alu_sub = 1'b1;
      unique case (op_code)
         ald_pkg::OP_ADD: alu_sub = 1'b0;
         ald_pkg::OP_ADD_CARRY: begin
            alu_sub = 1'b0;
            alu_cin = state_reg.flags[ald_pkg::FLAG_C];
         end
         ald_pkg::OP_MINUS_IMMEDIATE,
         ald_pkg::OP_COMPARE_IMMEDIATE: alu_b = op_imm;
         ald_pkg::OP_MINUS_IMMEDIATE_WITH_BORROW: begin
            alu_b = op_imm;
            alu_cin = state_reg.flags[ald_pkg::FLAG_C];
         end
         ald_pkg::OP_MINUS_WITH_BORROW,
         ald_pkg::OP_COMPARE_WITH_BORROW: alu_cin = state_reg.flags[ald_pkg::FLAG_C];
         default: ;
      endcase
   end

   ald_addsub u_addsub (
      .a(rd_val),
      .b(alu_b),
      .carry_in(alu_cin),
      .subtract(alu_sub),
      .result(alu_res),
      .carry(alu_c),
      .half(alu_h),
      .overflow(alu_v),
      .negative(alu_n),
      .zero(alu_z)
   );

   always_comb begin
      unique case (op_code)
         ald_pkg::OP_CONJUNCTION: logic_res = rd_val & rr_val;
         ald_pkg::OP_CONJUNCTION_IMMEDIATE: logic_res = rd_val & op_imm;
         ald_pkg::OP_DISJUNCTION: logic_res = rd_val | rr_val;
         ald_pkg::OP_DISJUNCTION_IMMEDIATE: logic_res = rd_val | op_imm;
         ald_pkg::OP_BITS_SET_IMMEDIATE: logic_res = rd_val | op_imm;
         ald_pkg::OP_BITS_CLEAR_IMMEDIATE: logic_res = rd_val & (ald_pkg::BYTE_ALL - op_imm);
         ald_pkg::OP_EXCLUSIVE_DISJUNCTION: logic_res = rd_val ^ rr_val;
         default: logic_res = rd_val & rd_val;
      endcase
      unique case (op_code)
         ald_pkg::OP_EQUAL_SKIP: skip_cond = (rd_val == rr_val);
         ald_pkg::OP_SKIP_REG_BIT_LOW: skip_cond = !rr_val[op_bit];
         ald_pkg::OP_SKIP_REG_BIT_HIGH: skip_cond = rr_val[op_bit];
         ald_pkg::OP_SKIP_IO_BIT_LOW: skip_cond = !io_bit_value;
         ald_pkg::OP_SKIP_IO_BIT_HIGH: skip_cond = io_bit_value;
         default: skip_cond = 1'b0;
      endcase
      word_res = (op_code == ald_pkg::OP_WORD_PLUS_IMMEDIATE) ?
         word_val + {10'h000, op_imm[5:0]} : word_val - {10'h000, op_imm[5:0]};
   end

   always_comb begin
      logic [2:0] ncyc;
      ncyc = ald_pkg::CYC_ONE;
      state_next = state_reg;
      state_next.done = 1'b0;
      state_next.peek = state_reg.gpr[peek_index];
      if (!state_reg.ready) begin
         state_next.cnt = state_reg.cnt - 3'h1;
         if (state_reg.cnt == 3'h1) begin
            state_next.ready = 1'b1;
            state_next.done = 1'b1;
         end
      end else if (accept) begin
         state_next.pc = state_reg.pc + ald_pkg::PC_STEP;
         unique case (op_code)
            ald_pkg::OP_ADD, ald_pkg::OP_ADD_CARRY, ald_pkg::OP_SUB, ald_pkg::OP_MINUS_IMMEDIATE,
            ald_pkg::OP_MINUS_WITH_BORROW, ald_pkg::OP_MINUS_IMMEDIATE_WITH_BORROW,
            ald_pkg::OP_COMPARE_REGS, ald_pkg::OP_COMPARE_WITH_BORROW,
            ald_pkg::OP_COMPARE_IMMEDIATE: begin
               if (op_code != ald_pkg::OP_COMPARE_REGS && op_code != ald_pkg::OP_COMPARE_WITH_BORROW &&
                   op_code != ald_pkg::OP_COMPARE_IMMEDIATE) begin
                  state_next.gpr[op_rd] = alu_res;
               end
               state_next.flags[ald_pkg::FLAG_C] = alu_c;
               state_next.flags[ald_pkg::FLAG_H] = alu_h;
               state_next.flags[ald_pkg::FLAG_V] = alu_v;
               state_next.flags[ald_pkg::FLAG_N] = alu_n;
               // Borrow forms only keep zero across a multi-byte chain
               if (op_code == ald_pkg::OP_MINUS_WITH_BORROW || op_code == ald_pkg::OP_COMPARE_WITH_BORROW ||
                   op_code == ald_pkg::OP_MINUS_IMMEDIATE_WITH_BORROW) begin
                  state_next.flags[ald_pkg::FLAG_Z] = alu_z && state_reg.flags[ald_pkg::FLAG_Z];
               end else begin
                  state_next.flags[ald_pkg::FLAG_Z] = alu_z;
               end
            end
            ald_pkg::OP_WORD_PLUS_IMMEDIATE, ald_pkg::OP_WORD_MINUS_IMMEDIATE: begin
               ncyc = ald_pkg::CYC_WORD;
               state_next.gpr[pair_lo] = word_res[7:0];
               state_next.gpr[pair_hi] = word_res[15:8];
               if (op_code == ald_pkg::OP_WORD_PLUS_IMMEDIATE) begin
                  state_next.flags[ald_pkg::FLAG_C] = word_val[15] && !word_res[15];
                  state_next.flags[ald_pkg::FLAG_V] = !word_val[15] && word_res[15];
               end else begin
                  state_next.flags[ald_pkg::FLAG_C] = !word_val[15] && word_res[15];
                  state_next.flags[ald_pkg::FLAG_V] = word_val[15] && !word_res[15];
               end
               state_next.flags[ald_pkg::FLAG_N] = word_res[15];
               state_next.flags[ald_pkg::FLAG_Z] = (word_res == 16'h0000);
               state_next.flags[ald_pkg::FLAG_S] = word_res[15] ^ state_next.flags[ald_pkg::FLAG_V];
            end
            ald_pkg::OP_CONJUNCTION, ald_pkg::OP_CONJUNCTION_IMMEDIATE, ald_pkg::OP_DISJUNCTION,
            ald_pkg::OP_DISJUNCTION_IMMEDIATE, ald_pkg::OP_EXCLUSIVE_DISJUNCTION,
            ald_pkg::OP_BITS_SET_IMMEDIATE, ald_pkg::OP_BITS_CLEAR_IMMEDIATE,
            ald_pkg::OP_ZERO_MINUS_TEST: begin
               state_next.gpr[op_rd] = logic_res;
               state_next.flags[ald_pkg::FLAG_Z] = (logic_res == 8'h00);
               state_next.flags[ald_pkg::FLAG_N] = logic_res[7];
               state_next.flags[ald_pkg::FLAG_V] = 1'b0;
            end
            ald_pkg::OP_POINTER_JUMP: begin
               ncyc = ald_pkg::CYC_PTR_JUMP;
               state_next.pc = zptr;
            end
            ald_pkg::OP_DIRECT_INVOKE, ald_pkg::OP_RELATIVE_INVOKE, ald_pkg::OP_POINTER_INVOKE: begin
               state_next.stk[state_reg.sp] = state_reg.pc + ald_pkg::PC_STEP;
               state_next.sp = state_reg.sp + 1'b1;
               if (op_code == ald_pkg::OP_DIRECT_INVOKE) begin
                  ncyc = ald_pkg::CYC_DIRECT_CALL;
                  state_next.stk[state_reg.sp] = state_reg.pc + ald_pkg::PC_CALL_STEP;
                  state_next.pc = op_target;
               end else if (op_code == ald_pkg::OP_RELATIVE_INVOKE) begin
                  ncyc = ald_pkg::CYC_REL_CALL;
                  state_next.pc = rel_target;
               end else begin
                  ncyc = ald_pkg::CYC_PTR_CALL;
                  state_next.pc = zptr;
               end
            end
            ald_pkg::OP_SUBROUTINE_EXIT, ald_pkg::OP_INTERRUPT_EXIT: begin
               ncyc = ald_pkg::CYC_EXIT;
               state_next.sp = state_reg.sp - 1'b1;
               state_next.pc = state_reg.stk[state_reg.sp - 1'b1];
               if (op_code == ald_pkg::OP_INTERRUPT_EXIT) begin
                  state_next.flags[ald_pkg::FLAG_I] = 1'b1;
               end
            end
            ald_pkg::OP_EQUAL_SKIP, ald_pkg::OP_SKIP_REG_BIT_LOW, ald_pkg::OP_SKIP_REG_BIT_HIGH,
            ald_pkg::OP_SKIP_IO_BIT_LOW, ald_pkg::OP_SKIP_IO_BIT_HIGH: begin
               if (skip_cond) begin
                  ncyc = next_is_two_word ? ald_pkg::CYC_SKIP_TWO : ald_pkg::CYC_SKIP_ONE;
                  state_next.pc = state_reg.pc + (next_is_two_word ? ald_pkg::PC_SKIP_TWO : ald_pkg::PC_SKIP_ONE);
               end
            end
            ald_pkg::OP_BRANCH_FLAG_HIGH, ald_pkg::OP_BRANCH_FLAG_LOW: begin
               if (state_reg.flags[op_bit] == (op_code == ald_pkg::OP_BRANCH_FLAG_HIGH)) begin
                  ncyc = ald_pkg::CYC_BRANCH_TAKEN;
                  state_next.pc = rel_target;
               end
            end
            default: ;
         endcase
         if (ncyc == ald_pkg::CYC_ONE) begin
            state_next.done = 1'b1;
         end else begin
            state_next.ready = 1'b0;
            state_next.cnt = ncyc - 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.ready <= 1'b1;
         state_reg.pc <= ald_pkg::PC_RESET;
         state_reg.flags <= ald_pkg::FLAGS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign op_ready = state_reg.ready;
   assign op_done = state_reg.done;
   assign pc = state_reg.pc;
   assign status_flags = state_reg.flags;
   assign peek_data = state_reg.peek;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_add_flags: assert property (accept && op_code == ald_pkg::OP_ADD |=>
      op_done && status_flags[ald_pkg::FLAG_C] == $past(alu_c) && status_flags[ald_pkg::FLAG_Z] == $past(alu_z))
      else $error("add result flags wrong");
   a_word_two_cycle: assert property (accept && op_code == ald_pkg::OP_WORD_MINUS_IMMEDIATE |=>
      !op_ready && !op_done ##1 op_ready && op_done)
      else $error("word op not two cycles");
   a_sub_stores: assert property (accept && op_code == ald_pkg::OP_SUB |=>
      state_reg.gpr[$past(op_rd)] == $past(rd_val) - $past(rr_val))
      else $error("subtract result wrong");
   a_logic_keeps_carry: assert property (accept && op_code == ald_pkg::OP_EXCLUSIVE_DISJUNCTION |=>
      status_flags[ald_pkg::FLAG_C] == $past(status_flags[ald_pkg::FLAG_C]) && !status_flags[ald_pkg::FLAG_V])
      else $error("logic op disturbed carry or overflow");
   a_bits_clear: assert property (accept && op_code == ald_pkg::OP_BITS_CLEAR_IMMEDIATE |=>
      state_reg.gpr[$past(op_rd)] == ($past(rd_val) & ~$past(op_imm)))
      else $error("bit clear result wrong");
   a_test_keeps_reg: assert property (accept && op_code == ald_pkg::OP_ZERO_MINUS_TEST |=>
      state_reg.gpr[$past(op_rd)] == $past(rd_val) && status_flags[ald_pkg::FLAG_Z] == ($past(rd_val) == 8'h00))
      else $error("test changed register or zero flag wrong");
   a_pointer_jump: assert property (accept && op_code == ald_pkg::OP_POINTER_JUMP |=>
      pc == $past(zptr) && status_flags == $past(status_flags) && !op_ready ##1 op_done)
      else $error("pointer jump wrong");
   a_direct_invoke: assert property (accept && op_code == ald_pkg::OP_DIRECT_INVOKE |=>
      (pc == $past(op_target) && !op_ready) ##1 !op_ready [*3] ##1 op_ready && op_done)
      else $error("direct invoke not five cycles");
   a_relative_invoke: assert property (accept && op_code == ald_pkg::OP_RELATIVE_INVOKE |=>
      (pc == $past(rel_target) && !op_ready) ##1 !op_ready [*2] ##1 op_done)
      else $error("relative invoke wrong");
   a_pointer_invoke: assert property (accept && op_code == ald_pkg::OP_POINTER_INVOKE |=>
      (pc == $past(zptr) && !op_ready) ##1 !op_ready [*2] ##1 op_done)
      else $error("pointer invoke wrong");
   a_equal_skip: assert property (accept && op_code == ald_pkg::OP_EQUAL_SKIP && rd_val == rr_val
      && !next_is_two_word |=> pc == $past(pc) + 16'h0002 && status_flags == $past(status_flags))
      else $error("equal skip did not skip");
   a_compare_no_store: assert property (accept && op_code == ald_pkg::OP_COMPARE_REGS |=>
      state_reg.gpr[$past(op_rd)] == $past(rd_val) && status_flags[ald_pkg::FLAG_C] == $past(alu_c))
      else $error("compare stored or carry wrong");
   a_reg_bit_skip: assert property (accept && op_code == ald_pkg::OP_SKIP_REG_BIT_HIGH && !rr_val[op_bit]
      |=> pc == $past(pc) + 16'h0001 && op_done)
      else $error("bit skip taken when bit low");
   a_io_bit_skip: assert property (accept && op_code == ald_pkg::OP_SKIP_IO_BIT_LOW && !io_bit_value
      && next_is_two_word |=> (pc == $past(pc) + 16'h0003 && !op_ready) ##1 !op_ready ##1 op_done)
      else $error("io bit skip wrong");
   a_branch_taken: assert property (accept && op_code == ald_pkg::OP_BRANCH_FLAG_HIGH &&
      status_flags[op_bit] |=> pc == $past(rel_target) && !op_ready ##1 op_ready)
      else $error("taken branch wrong");
   a_exit_sets_i: assert property (accept && op_code == ald_pkg::OP_INTERRUPT_EXIT |=>
      status_flags[ald_pkg::FLAG_I] && !op_ready [*4] ##1 op_done)
      else $error("interrupt exit wrong");

   c_invoke_exit: cover property (accept && op_code == ald_pkg::OP_RELATIVE_INVOKE ##[4:40]
      accept && op_code == ald_pkg::OP_SUBROUTINE_EXIT);
   c_skip_two: cover property (accept && skip_cond && next_is_two_word);
   c_branch_untaken: cover property (accept && op_code == ald_pkg::OP_BRANCH_FLAG_LOW && status_flags[op_bit]);
   c_back_to_back: cover property (accept && op_code == ald_pkg::OP_ADD ##1 accept && op_code == ald_pkg::OP_ADD_CARRY);
endmodule

// ==== ald_pkg.sv ====
// Shared constants and opcode type for the execution datapath
package ald_pkg;
   // Status flag bit positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;
   // Reset values and all-ones byte mask
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] BYTE_ALL = 8'hFF;
   // Z pointer register pair
   localparam logic [4:0] ZPTR_LOW = 5'h1E;
   localparam logic [4:0] ZPTR_HIGH = 5'h1F;
   // Cycle counts
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_PTR_JUMP = 3'h2;
   localparam logic [2:0] CYC_DIRECT_CALL = 3'h5;
   localparam logic [2:0] CYC_REL_CALL = 3'h4;
   localparam logic [2:0] CYC_PTR_CALL = 3'h4;
   localparam logic [2:0] CYC_EXIT = 3'h5;
   localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;
   // Program counter steps
   localparam logic [15:0] PC_STEP = 16'h0001;
   localparam logic [15:0] PC_CALL_STEP = 16'h0002;
   localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
   localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

   typedef enum logic [5:0] {
      OP_NONE = 6'h00,
      OP_ADD = 6'h01,
      OP_ADD_CARRY = 6'h02,
      OP_WORD_PLUS_IMMEDIATE = 6'h03,
      OP_SUB = 6'h04,
      OP_MINUS_IMMEDIATE = 6'h05,
      OP_MINUS_WITH_BORROW = 6'h06,
      OP_MINUS_IMMEDIATE_WITH_BORROW = 6'h07,
      OP_WORD_MINUS_IMMEDIATE = 6'h08,
      OP_CONJUNCTION = 6'h09,
      OP_CONJUNCTION_IMMEDIATE = 6'h0A,
      OP_DISJUNCTION = 6'h0B,
      OP_DISJUNCTION_IMMEDIATE = 6'h0C,
      OP_EXCLUSIVE_DISJUNCTION = 6'h0D,
      OP_BITS_SET_IMMEDIATE = 6'h0E,
      OP_BITS_CLEAR_IMMEDIATE = 6'h0F,
      OP_ZERO_MINUS_TEST = 6'h10,
      OP_POINTER_JUMP = 6'h11,
      OP_DIRECT_INVOKE = 6'h12,
      OP_RELATIVE_INVOKE = 6'h13,
      OP_POINTER_INVOKE = 6'h14,
      OP_SUBROUTINE_EXIT = 6'h15,
      OP_INTERRUPT_EXIT = 6'h16,
      OP_EQUAL_SKIP = 6'h17,
      OP_COMPARE_REGS = 6'h18,
      OP_COMPARE_WITH_BORROW = 6'h19,
      OP_COMPARE_IMMEDIATE = 6'h1A,
      OP_SKIP_REG_BIT_LOW = 6'h1B,
      OP_SKIP_REG_BIT_HIGH = 6'h1C,
      OP_SKIP_IO_BIT_LOW = 6'h1D,
      OP_SKIP_IO_BIT_HIGH = 6'h1E,
      OP_BRANCH_FLAG_HIGH = 6'h1F,
      OP_BRANCH_FLAG_LOW = 6'h20
   } ald_op_t;
endpackage

// ==== ald_addsub.sv ====
// Eight-bit adder and subtractor with status flag outputs
`timescale 1ns/1ps
module ald_addsub (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic carry_in,
   input wire logic subtract,
   output logic [7:0] result,
   output logic carry,
   output logic half,
   output logic overflow,
   output logic negative,
   output logic zero
);
   logic [7:0] b_eff;
   logic [8:0] sum;
   logic into_four;

   // Subtraction as a + ~b + !borrow
   always_comb begin
      b_eff = subtract ? ~b : b;
      sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, subtract ^ carry_in};
      result = sum[7:0];
      carry = subtract ? ~sum[8] : sum[8];
      into_four = a[4] ^ b_eff[4] ^ sum[4];
      half = subtract ? ~into_four : into_four;
      overflow = (a[7] == b_eff[7]) && (sum[7] != a[7]);
      negative = sum[7];
      zero = (sum[7:0] == 8'h00);
   end
endmodule

// ==== tb_cpu_alu_and_branch_datapath.sv ====
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
module tb_cpu_alu_and_branch_datapath;
   typedef struct {logic [15:0] pc; logic [7:0] fl; logic [7:0] pk; int unsigned at;} ald_note_t;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic op_valid = 1'b0;
   ald_pkg::ald_op_t op_code = ald_pkg::OP_NONE;
   logic [4:0] op_rd = 5'h00;
   logic [4:0] op_rr = 5'h00;
   logic [7:0] op_imm = 8'h00;
   logic [2:0] op_bit = 3'h0;
   logic [11:0] op_offset = 12'h000;
   logic [15:0] op_target = 16'h0000;
   logic next_is_two_word = 1'b0;
   logic io_bit_value = 1'b0;
   logic [4:0] peek_index = 5'h00;
   logic op_ready;
   logic op_done;
   logic [15:0] pc;
   logic [7:0] status_flags;
   logic [7:0] peek_data;
   int unsigned bad_count = 0;
   int unsigned n_checks = 0;
   int unsigned cyc = 0;
   logic [7:0] r [32];
   logic [7:0] f;
   logic [15:0] p;
   logic [15:0] stk [$];
   ald_note_t q [$];
   ald_note_t nt;

   ald_core #(.STACK_DEPTH(8)) dut (.clock(clock), .reset(reset), .op_valid(op_valid), .op_code(op_code),
      .op_rd(op_rd), .op_rr(op_rr), .op_imm(op_imm), .op_bit(op_bit), .op_offset(op_offset),
      .op_target(op_target), .next_is_two_word(next_is_two_word), .io_bit_value(io_bit_value),
      .peek_index(peek_index), .op_ready(op_ready), .op_done(op_done), .pc(pc),
      .status_flags(status_flags), .peek_data(peek_data));

   always #2.5 clock = ~clock;

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Reference model, updated at each accept edge
   task automatic model(input ald_pkg::ald_op_t oc, input logic [4:0] rd, input logic [4:0] rr, input logic [7:0] k,
                        input logic [2:0] b, input logic [11:0] o, input logic [15:0] t, input logic nx,
                        input logic io, output int n);
      logic [7:0] a;
      logic [7:0] c;
      logic [7:0] res;
      logic [8:0] w9;
      logic [4:0] h5;
      logic [15:0] w;
      logic [15:0] wr;
      logic [15:0] nxt;
      logic [15:0] rel;
      logic cin, sb, ar, lg, ns, sk, wb;
      a = r[rd];
      c = r[rr];
      n = 1;
      res = 8'h00;
      nxt = p + 16'h0001;
      rel = p + {{4{o[11]}}, o} + 16'h0001;
      {cin, sb, ar, lg, ns, sk, wb} = 7'h00;
      case (oc)
         ald_pkg::OP_ADD: ar = 1'b1;
         ald_pkg::OP_ADD_CARRY: {ar, cin} = {1'b1, f[0]};
         ald_pkg::OP_SUB: {ar, sb} = 2'h3;
         ald_pkg::OP_MINUS_IMMEDIATE: {ar, sb, c} = {2'h3, k};
         ald_pkg::OP_MINUS_WITH_BORROW: {ar, sb, wb, cin} = {3'h7, f[0]};
         ald_pkg::OP_MINUS_IMMEDIATE_WITH_BORROW: {ar, sb, wb, cin, c} = {3'h7, f[0], k};
         ald_pkg::OP_COMPARE_REGS: {ar, sb, ns} = 3'h7;
         ald_pkg::OP_COMPARE_WITH_BORROW: {ar, sb, ns, wb, cin} = {4'hF, f[0]};
         ald_pkg::OP_COMPARE_IMMEDIATE: {ar, sb, ns, c} = {3'h7, k};
         ald_pkg::OP_CONJUNCTION: {lg, res} = {1'b1, a & c};
         ald_pkg::OP_CONJUNCTION_IMMEDIATE: {lg, res} = {1'b1, a & k};
         ald_pkg::OP_DISJUNCTION: {lg, res} = {1'b1, a | c};
         ald_pkg::OP_DISJUNCTION_IMMEDIATE, ald_pkg::OP_BITS_SET_IMMEDIATE: {lg, res} = {1'b1, a | k};
         ald_pkg::OP_EXCLUSIVE_DISJUNCTION: {lg, res} = {1'b1, a ^ c};
         ald_pkg::OP_BITS_CLEAR_IMMEDIATE: {lg, res} = {1'b1, a & (8'hFF - k)};
         ald_pkg::OP_ZERO_MINUS_TEST: {lg, res} = {1'b1, a & a};
         ald_pkg::OP_WORD_PLUS_IMMEDIATE, ald_pkg::OP_WORD_MINUS_IMMEDIATE: begin
            sb = (oc == ald_pkg::OP_WORD_MINUS_IMMEDIATE);
            w = {r[{rd[4:1], 1'b1}], r[{rd[4:1], 1'b0}]};
            wr = sb ? w - {10'h000, k[5:0]} : w + {10'h000, k[5:0]};
            f[0] = sb ? (wr[15] & ~w[15]) : (~wr[15] & w[15]);
            f[3] = sb ? (w[15] & ~wr[15]) : (~w[15] & wr[15]);
            f[2] = wr[15];
            f[1] = (wr == 16'h0000);
            f[4] = f[2] ^ f[3];
            {r[{rd[4:1], 1'b1}], r[{rd[4:1], 1'b0}]} = wr;
            n = 2;
         end
         ald_pkg::OP_POINTER_JUMP: begin
            nxt = {r[31], r[30]};
            n = 2;
         end
         ald_pkg::OP_DIRECT_INVOKE: begin
            stk.push_back(p + 16'h0002);
            nxt = t;
            n = 5;
         end
         ald_pkg::OP_RELATIVE_INVOKE, ald_pkg::OP_POINTER_INVOKE: begin
            stk.push_back(nxt);
            nxt = (oc == ald_pkg::OP_POINTER_INVOKE) ? {r[31], r[30]} : rel;
            n = 4;
         end
         ald_pkg::OP_SUBROUTINE_EXIT, ald_pkg::OP_INTERRUPT_EXIT: begin
            nxt = stk.pop_back();
            f[7] = f[7] | (oc == ald_pkg::OP_INTERRUPT_EXIT);
            n = 5;
         end
         ald_pkg::OP_EQUAL_SKIP: sk = (a == c);
         ald_pkg::OP_SKIP_REG_BIT_LOW: sk = ~c[b];
         ald_pkg::OP_SKIP_REG_BIT_HIGH: sk = c[b];
         ald_pkg::OP_SKIP_IO_BIT_LOW: sk = ~io;
         ald_pkg::OP_SKIP_IO_BIT_HIGH: sk = io;
         ald_pkg::OP_BRANCH_FLAG_HIGH, ald_pkg::OP_BRANCH_FLAG_LOW: begin
            if (f[b] == (oc == ald_pkg::OP_BRANCH_FLAG_HIGH)) begin
               nxt = rel;
               n = 2;
            end
         end
         default: ;
      endcase
      if (ar) begin
         w9 = sb ? {1'b0, a} - {1'b0, c} - {8'h00, cin} : {1'b0, a} + {1'b0, c} + {8'h00, cin};
         h5 = sb ? {1'b0, a[3:0]} - {1'b0, c[3:0]} - {4'h0, cin} : {1'b0, a[3:0]} + {1'b0, c[3:0]} + {4'h0, cin};
         res = w9[7:0];
         f[0] = w9[8];
         f[5] = h5[4];
         f[3] = (a[7] ^ res[7]) & (sb ? (a[7] ^ c[7]) : ~(a[7] ^ c[7]));
         f[1] = (res == 8'h00) & (~wb | f[1]);
         f[2] = res[7];
      end
      if (lg) begin
         f[1] = (res == 8'h00);
         f[2] = res[7];
         f[3] = 1'b0;
      end
      if ((ar & ~ns) | lg) begin
         r[rd] = res;
      end
      if (sk) begin
         n = nx ? 3 : 2;
         nxt = p + (nx ? 16'h0003 : 16'h0002);
      end
      p = nxt;
   endtask

   task automatic issue(input ald_pkg::ald_op_t oc, input logic [4:0] rd, input logic [4:0] rr, input logic [7:0] k,
                        input logic [2:0] b, input logic [11:0] o, input logic [15:0] t, input logic nx,
                        input logic io);
      int g;
      int n;
      logic [7:0] pre;
      op_valid <= 1'b1;
      op_code <= oc;
      op_rd <= rd;
      op_rr <= rr;
      op_imm <= k;
      op_bit <= b;
      op_offset <= o;
      op_target <= t;
      next_is_two_word <= nx;
      io_bit_value <= io;
      peek_index <= rd;
      g = 0;
      do begin
         @(posedge clock);
         g++;
      end while (op_ready !== 1'b1 && g < 10);
      pre = r[rd];
      model(oc, rd, rr, k, b, o, t, nx, io, n);
      q.push_back('{p, f, (n == 1) ? pre : r[rd], cyc + n});
      // Hold peek_index until the result shows
      repeat (n - 1) @(posedge clock);
   endtask

   task automatic alu(input ald_pkg::ald_op_t oc, input logic [4:0] rd, input logic [7:0] k);
      issue(oc, rd, 5'h00, k, 3'h0, 12'h000, 16'h0000, 1'b0, 1'b0);
   endtask

   task automatic do_reset();
      reset <= 1'b1;
      op_valid <= 1'b0;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      r = '{default: 8'h00};
      f = 8'h00;
      p = 16'h0000;
      stk.delete();
      @(posedge clock);
      chk("reset pc", 16'h0000, pc);
      chk("reset flags", 16'h0000, {8'h00, status_flags});
      chk("reset ready", 16'h0001, {15'h0000, op_ready});
   endtask

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         conclude();
      end
      if (!reset && op_done === 1'b1) begin
         if (q.size() == 0) begin
            chk("spurious done", 16'h0000, 16'h0001);
         end else begin
            nt = q.pop_front();
            chk("pc", nt.pc, pc);
            chk("flags", {8'h00, nt.fl}, {8'h00, status_flags});
            chk("peek", {8'h00, nt.pk}, {8'h00, peek_data});
            chk("cycles", nt.at[15:0], cyc[15:0]);
         end
      end
   end

   initial begin
      int unsigned c;
      logic [4:0] d;
      void'($urandom(42));
      do_reset();
      for (int i = 0; i < 32; i++) begin
         alu(ald_pkg::OP_DISJUNCTION_IMMEDIATE, 5'(i), 8'($urandom));
      end
      for (int i = 0; i < 300; i++) begin
         c = $urandom % 33;
         if (c >= 17 && c <= 22) begin
            c = c + 10;
         end
         d = 5'($urandom);
         issue(ald_pkg::ald_op_t'(c[5:0]), d, ($urandom % 4 == 0) ? d : 5'($urandom), 8'($urandom), 3'($urandom),
               12'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
      end
      alu(ald_pkg::OP_DISJUNCTION_IMMEDIATE, 5'h18, 8'hFF);
      alu(ald_pkg::OP_DISJUNCTION_IMMEDIATE, 5'h19, 8'hFF);
      alu(ald_pkg::OP_WORD_PLUS_IMMEDIATE, 5'h18, 8'h3F);
      alu(ald_pkg::OP_CONJUNCTION_IMMEDIATE, 5'h1A, 8'h00);
      alu(ald_pkg::OP_CONJUNCTION_IMMEDIATE, 5'h1B, 8'h00);
      alu(ald_pkg::OP_WORD_MINUS_IMMEDIATE, 5'h1A, 8'h01);
      issue(ald_pkg::OP_DIRECT_INVOKE, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 16'h1234, 1'b0, 1'b0);
      issue(ald_pkg::OP_RELATIVE_INVOKE, 5'h00, 5'h00, 8'h00, 3'h0, 12'hFF0, 16'h0000, 1'b0, 1'b0);
      alu(ald_pkg::OP_POINTER_INVOKE, 5'h00, 8'h00);
      alu(ald_pkg::OP_SUBROUTINE_EXIT, 5'h00, 8'h00);
      alu(ald_pkg::OP_INTERRUPT_EXIT, 5'h00, 8'h00);
      alu(ald_pkg::OP_SUBROUTINE_EXIT, 5'h00, 8'h00);
      alu(ald_pkg::OP_POINTER_JUMP, 5'h00, 8'h00);
      op_valid <= 1'b0;
      repeat (6) @(posedge clock);
      do_reset();
      alu(ald_pkg::OP_ADD, 5'h01, 8'h00);
      op_valid <= 1'b0;
      repeat (8) @(posedge clock);
      chk("pending", 16'h0000, 16'(q.size()));
      conclude();
   end
endmodule
